// ===== spi_raw_irq_status_clear.sv
/*
 * Interrupt raw status, mask, masked status and read-to-clear registers
 * of a serial peripheral controller, plus a sticky event register that
 * drives one level interrupt output.
 * Assumes the buffer and serial engine give full/empty levels and one-cycle
 * overflow, underflow and contention pulses, all on i_core_clk.
 */
// Added by the designer: the strobed register port.
// Summary of operation
// - bit 5 shows raw contention; absent, reading zero, in slave builds.
// - bit 4 shows raw receive-buffer-full, one while active.
// - bit 3 shows raw receive overflow, one while active.
// - bit 2 shows raw receive underflow, one while active.
// - bit 1 shows raw transmit overflow, one while active.
// - bit 0 shows raw transmit-empty; bits 31:6 reserved; all reset zero.
// - reading transmit-overflow clear returns its state in bit 0, then clears.
// - reading receive-overflow clear returns its state in bit 0, then clears.
// - reading receive-underflow clear returns its state in bit 0, then clears.
// - writes to the three clear registers change nothing and store nothing.
// - masked status is raw AND mask; mask zero suppresses, one passes.
// - reading combined clear clears overflow, underflow, contention; writes ignored.
`timescale 1ns/1ps

module spi_raw_irq_status_clear #(
	parameter bit MASTER_MODE = 1'b1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [spi_irq_pkg::ADDR_W-1:0] i_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [spi_irq_pkg::DATA_W-1:0] o_rdata,
	// buffer levels
	input wire logic i_txe_empty,
	input wire logic i_rxf_full,
	// error event pulses
	input wire logic i_txo_evt,
	input wire logic i_rxu_evt,
	input wire logic i_rxo_evt,
	input wire logic i_mst_evt,
	// interrupt
	output logic o_irq
);
	import spi_irq_pkg::*;

	// exact offset match, shared by read and write decode
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] off
	);
		addr_hit = (addr == off);
	endfunction : addr_hit

	// widen a source vector to the data bus, upper bits zero
	function automatic logic [DATA_W-1:0] src_word(input src_vec_t v);
		src_word = {{(DATA_W-NUM_SRC){1'b0}}, v};
	endfunction : src_word

	// widen a single flag into bit 0 of a data word
	function automatic logic [DATA_W-1:0] flag_word(input logic f);
		flag_word = {{(DATA_W-1){1'b0}}, f};
	endfunction : flag_word

	// source bits that exist in this build
	localparam src_vec_t PRESENT = MASTER_MODE ? MASK_RST : (MASK_RST & ~(6'h01 << BIT_MST));

	typedef struct packed {
		src_vec_t mask;
		logic [DATA_W-1:0] rdata;
	} main_state_t;

	main_state_t state_r;
	main_state_t state_nxt;

	sticky_vec_t sticky_set;
	sticky_vec_t sticky_clr;
	sticky_vec_t sticky;
	src_vec_t raw;
	src_vec_t masked;
	src_vec_t evt_status;
	logic rd_txo_clr;
	logic rd_rxo_clr;
	logic rd_rxu_clr;
	logic rd_all_clr;
	logic wr_mask;
	logic wr_evt;
	logic [DATA_W-1:0] rd_word;

	// read decode of the clearing registers
	always_comb
	begin
		rd_txo_clr = i_rd && addr_hit(i_addr, OFF_TXO_CLR);
		rd_rxo_clr = i_rd && addr_hit(i_addr, OFF_RXO_CLR);
		rd_rxu_clr = i_rd && addr_hit(i_addr, OFF_RXU_CLR);
		rd_all_clr = i_rd && addr_hit(i_addr, OFF_ALL_CLR);
	end

	// write decode: only mask and event status take writes
	always_comb
	begin
		wr_mask = i_wr && addr_hit(i_addr, OFF_MASK);
		wr_evt = i_wr && addr_hit(i_addr, OFF_EVT_STAT);
	end

	// error pulses into the sticky flags, contention only in master builds
	always_comb
	begin
		sticky_set = '0;
		sticky_set[STK_TXO] = i_txo_evt;
		sticky_set[STK_RXU] = i_rxu_evt;
		sticky_set[STK_RXO] = i_rxo_evt;
		sticky_set[STK_MST] = i_mst_evt && MASTER_MODE;
	end

	// clears come from reads only; writes never reach here
	always_comb
	begin
		sticky_clr = '0;
		sticky_clr[STK_TXO] = rd_txo_clr || rd_all_clr;
		sticky_clr[STK_RXO] = rd_rxo_clr || rd_all_clr;
		sticky_clr[STK_RXU] = rd_rxu_clr || rd_all_clr;
		sticky_clr[STK_MST] = rd_all_clr;
	end

	// error flags hold until a clearing read, set wins
	rc_flag_bank #(
		.WIDTH(NUM_STICKY),
		.RST_VAL(STICKY_RST)
	) u_err_flags (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_set(sticky_set),
		.i_clr(sticky_clr),
		.o_flag(sticky)
	);

	// raw status: buffer bits follow the level, error bits the flags
	always_comb
	begin
		raw = RAW_RST;
		raw[BIT_TXE] = i_txe_empty;
		raw[BIT_TXO] = sticky[STK_TXO];
		raw[BIT_RXU] = sticky[STK_RXU];
		raw[BIT_RXO] = sticky[STK_RXO];
		raw[BIT_RXF] = i_rxf_full;
		raw[BIT_MST] = sticky[STK_MST] && MASTER_MODE;
	end

	// masked status
	assign masked = raw & state_r.mask;

	// sticky events on rising edges of the raw sources
	w1c_event_reg #(
		.WIDTH(NUM_SRC),
		.RST_VAL(EVT_RST)
	) u_evt_stat (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_level(raw),
		.i_clr_wr(wr_evt),
		.i_clr_data(i_wdata[NUM_SRC-1:0]),
		.o_status(evt_status)
	);

	// read mux; unmapped and reserved bits read zero
	always_comb
	begin
		rd_word = RDATA_RST;
		case (1'b1)
			addr_hit(i_addr, OFF_MASK): rd_word = src_word(state_r.mask);
			addr_hit(i_addr, OFF_MASKED): rd_word = src_word(masked);
			addr_hit(i_addr, OFF_RAW): rd_word = src_word(raw);
			addr_hit(i_addr, OFF_TXO_CLR): rd_word = flag_word(raw[BIT_TXO]);
			addr_hit(i_addr, OFF_RXO_CLR): rd_word = flag_word(raw[BIT_RXO]);
			addr_hit(i_addr, OFF_RXU_CLR): rd_word = flag_word(raw[BIT_RXU]);
			addr_hit(i_addr, OFF_ALL_CLR): rd_word = flag_word(|masked);
			addr_hit(i_addr, OFF_EVT_STAT): rd_word = src_word(evt_status);
			default: rd_word = RDATA_RST;
		endcase
	end

	// next state: mask writes, read data for exactly one cycle
	always_comb
	begin
		state_nxt = state_r;
		if (wr_mask)
			state_nxt.mask = i_wdata[NUM_SRC-1:0] & PRESENT;
		state_nxt.rdata = i_rd ? rd_word : RDATA_RST;
	end

	// state register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			state_r <= '{mask: MASK_RST & PRESENT, rdata: RDATA_RST};
		else
			state_r <= state_nxt;
	end

	// outputs
	assign o_rdata = state_r.rdata;
	assign o_irq = |(evt_status & state_r.mask);

endmodule : spi_raw_irq_status_clear

// ===== spi_irq_pkg.sv
/*
 * Constants for the serial controller interrupt status and clear logic:
 * register offsets, source bit positions, reset values and vector types.
 * Assumes byte offsets on an 8-bit register address and 32-bit data.
 */
package spi_irq_pkg;

	// register address and data widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// number of interrupt sources
	localparam int NUM_SRC = 6;

	// number of sources held by read-to-clear flags
	localparam int NUM_STICKY = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_MASKED = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_RAW = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_TXO_CLR = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_RXO_CLR = 8'h3c;
	localparam logic [ADDR_W-1:0] OFF_RXU_CLR = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_ALL_CLR = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h70;

	// source bit positions in raw, mask, masked and event registers
	localparam int BIT_TXE = 0;
	localparam int BIT_TXO = 1;
	localparam int BIT_RXU = 2;
	localparam int BIT_RXO = 3;
	localparam int BIT_RXF = 4;
	localparam int BIT_MST = 5;

	// positions inside the read-to-clear flag bank
	localparam int STK_TXO = 0;
	localparam int STK_RXU = 1;
	localparam int STK_RXO = 2;
	localparam int STK_MST = 3;

	// bit that a clear register returns its flag in
	localparam int BIT_CLR_FLAG = 0;

	// reset values
	localparam logic [NUM_SRC-1:0] RAW_RST = 6'h00;
	localparam logic [NUM_SRC-1:0] MASK_RST = 6'h3f;
	localparam logic [NUM_SRC-1:0] EVT_RST = 6'h00;
	localparam logic [NUM_STICKY-1:0] STICKY_RST = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// vector types
	typedef logic [NUM_SRC-1:0] src_vec_t;
	typedef logic [NUM_STICKY-1:0] sticky_vec_t;

endpackage : spi_irq_pkg

// ===== rc_flag_bank.sv
/*
 * Bank of sticky flags set by event pulses and cleared by a clear vector.
 * A set in the same cycle as its clear wins, so no event is lost.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module rc_flag_bank #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// set and clear
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clr,
	// flags
	output logic [WIDTH-1:0] o_flag
);
	import spi_irq_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] flag;
	} bank_state_t;

	bank_state_t state_r;
	bank_state_t state_nxt;

	// hold until cleared, set beats clear
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.flag = (state_r.flag & ~i_clr) | i_set;
	end

	// state register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			state_r <= '{flag: RST_VAL};
		else
			state_r <= state_nxt;
	end

	assign o_flag = state_r.flag;

endmodule : rc_flag_bank

// ===== w1c_event_reg.sv
/*
 * Event status register: a rising edge of each level input sets a sticky
 * bit, software clears it by writing a one. Set wins over the clear.
 * Assumes level inputs synchronous to the one clock.
 */
`timescale 1ns/1ps

module w1c_event_reg #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// watched levels
	input wire logic [WIDTH-1:0] i_level,
	// write-one-to-clear
	input wire logic i_clr_wr,
	input wire logic [WIDTH-1:0] i_clr_data,
	// sticky events
	output logic [WIDTH-1:0] o_status
);
	import spi_irq_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] level_prev;
		logic [WIDTH-1:0] status;
	} evt_state_t;

	evt_state_t state_r;
	evt_state_t state_nxt;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] clr;

	// edge detect, clear and set
	always_comb
	begin
		rise = i_level & ~state_r.level_prev;
		clr = i_clr_wr ? i_clr_data : '0;
		state_nxt = state_r;
		state_nxt.level_prev = i_level;
		state_nxt.status = (state_r.status & ~clr) | rise;
	end

	// state register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			// take the present levels so a level already high gives no false edge
			state_r <= '{level_prev: i_level, status: RST_VAL};
		else
			state_r <= state_nxt;
	end

	assign o_status = state_r.status;

endmodule : w1c_event_reg

// ===== spi_irq_asserts.sv
/*
 * Checker for the raw status and read-to-clear registers.
 * Assumes it sees only the top module's ports, attached by bind.
 */
`timescale 1ns/1ps

module spi_irq_asserts #(
	parameter bit MASTER_MODE = 1'b1
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [spi_irq_pkg::ADDR_W-1:0] i_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [spi_irq_pkg::DATA_W-1:0] o_rdata,
	// sources
	input wire logic i_txe_empty,
	input wire logic i_rxf_full,
	input wire logic i_txo_evt,
	input wire logic i_rxu_evt,
	input wire logic i_rxo_evt,
	input wire logic i_mst_evt,
	input wire logic o_irq
);
	import spi_irq_pkg::*;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// raw status read strobe
	logic rd_raw;
	assign rd_raw = i_rd && i_addr == OFF_RAW;
	// event, an idle bus cycle, then raw read shows the sticky bit
	property p_set(logic e, int b);
		e ##1 !i_rd ##1 rd_raw |=> o_rdata[b];
	endproperty
	// clearing read, quiet cycle, same read again returns zero
	property p_clr(logic e, logic [ADDR_W-1:0] off);
		(i_rd && i_addr == off && !e) ##1 (!i_rd && !e) ##1 (i_rd && i_addr == off)
			|=> !o_rdata[BIT_CLR_FLAG];
	endproperty
	txe_raw_a: assert property (rd_raw |=> o_rdata[BIT_TXE] == $past(i_txe_empty))
		else $error("raw empty bit wrong");
	rxf_raw_a: assert property (rd_raw |=> o_rdata[BIT_RXF] == $past(i_rxf_full))
		else $error("raw full bit wrong");
	raw_resv_a: assert property (rd_raw |=> o_rdata[31:6] == 26'h0)
		else $error("raw reserved bits set");
	txo_set_a: assert property (p_set(i_txo_evt, BIT_TXO))
		else $error("tx overflow not shown");
	rxu_set_a: assert property (p_set(i_rxu_evt, BIT_RXU))
		else $error("rx underflow not shown");
	rxo_set_a: assert property (p_set(i_rxo_evt, BIT_RXO))
		else $error("rx overflow not shown");
	mst_set_a: assert property (p_set(i_mst_evt && MASTER_MODE, BIT_MST))
		else $error("contention not shown");
	txo_clr_a: assert property (p_clr(i_txo_evt, OFF_TXO_CLR))
		else $error("tx overflow not cleared");
	rxo_clr_a: assert property (p_clr(i_rxo_evt, OFF_RXO_CLR))
		else $error("rx overflow not cleared");
	rxu_clr_a: assert property (p_clr(i_rxu_evt, OFF_RXU_CLR))
		else $error("rx underflow not cleared");
	// main scenarios
	cover property (rd_raw ##1 o_rdata[BIT_MST]);
	cover property (o_irq);
	cover property (i_rd && i_addr == OFF_ALL_CLR);
endmodule : spi_irq_asserts

bind spi_raw_irq_status_clear spi_irq_asserts #(.MASTER_MODE(MASTER_MODE)) chk (.*);

// ===== tb.sv
/*
 * Self-checking bench for the raw status and clear block.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end

module tb;
	import spi_irq_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_txe_empty = 1'b0;
	logic i_rxf_full = 1'b0;
	logic [3:0] evt = '0;
	logic [DATA_W-1:0] o_rdata;
	logic o_irq;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] o_rdata_slv;
	logic o_irq_slv;
	logic [DATA_W-1:0] d_slv;
	int mismatches = 0;
	int check_count = 0;
	// block under test, events txo rxu rxo mst
	spi_raw_irq_status_clear dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_txe_empty(i_txe_empty), .i_rxf_full(i_rxf_full), .i_txo_evt(evt[0]),
		.i_rxu_evt(evt[1]), .i_rxo_evt(evt[2]), .i_mst_evt(evt[3]), .o_irq(o_irq));
	// slave build on the same stimulus: contention bit absent
	spi_raw_irq_status_clear #(.MASTER_MODE(1'b0)) dut_slv (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata_slv), .i_txe_empty(i_txe_empty), .i_rxf_full(i_rxf_full),
		.i_txo_evt(evt[0]), .i_rxu_evt(evt[1]), .i_rxo_evt(evt[2]), .i_mst_evt(evt[3]),
		.o_irq(o_irq_slv));
	// 50 mhz clock
	always #10 i_core_clk = ~i_core_clk;
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	// read data stand in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		d_slv = o_rdata_slv;
	endtask : rd
	task automatic pulse(input int i);
		@(posedge i_core_clk);
		evt[i] <= 1'b1;
		@(posedge i_core_clk);
		evt[i] <= 1'b0;
	endtask : pulse
	task automatic t_reset();
		rd(OFF_RAW);
		`CHK(d, 32'h0000_0000)
		rd(OFF_MASK);
		`CHK(d, 32'h0000_003f)
		`CHK(d_slv, 32'h0000_001f)
		$display("test reset done");
	endtask : t_reset
	task automatic t_levels();
		@(posedge i_core_clk);
		i_txe_empty <= 1'b1;
		i_rxf_full <= 1'b1;
		rd(OFF_RAW);
		`CHK(d, 32'h0000_0011)
		@(posedge i_core_clk);
		i_txe_empty <= 1'b0;
		rd(OFF_RAW);
		`CHK(d, 32'h0000_0010)
		$display("test levels done");
	endtask : t_levels
	task automatic t_mask();
		`CHK(o_irq, 1'b1)
		`CHK(o_irq_slv, 1'b1)
		wr(OFF_MASK, 32'h0000_0000);
		rd(OFF_MASKED);
		`CHK(d, 32'h0000_0000)
		`CHK(o_irq, 1'b0)
		wr(OFF_MASK, 32'h0000_0010);
		rd(OFF_MASKED);
		`CHK(d, 32'h0000_0010)
		`CHK(o_irq, 1'b1)
		wr(OFF_EVT_STAT, 32'h0000_003f);
		i_rxf_full <= 1'b0;
		wr(OFF_MASK, 32'h0000_003f);
		#1 `CHK(o_irq, 1'b0)
		$display("test mask done");
	endtask : t_mask
	task automatic t_errors();
		int pos[4] = '{BIT_TXO, BIT_RXU, BIT_RXO, BIT_MST};
		logic [ADDR_W-1:0] clr[3] = '{OFF_TXO_CLR, OFF_RXU_CLR, OFF_RXO_CLR};
		for (int i = 0; i < 4; i++)
		begin
			pulse(i);
			rd(OFF_RAW);
			`CHK(d[pos[i]], 1'b1)
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(clr[i], 32'hffff_ffff);
			rd(clr[i]);
			`CHK(d, 32'h0000_0001)
			rd(clr[i]);
			`CHK(d, 32'h0000_0000)
		end
		wr(OFF_ALL_CLR, 32'hffff_ffff);
		rd(OFF_RAW);
		`CHK(d, 32'h0000_0020)
		`CHK(d_slv, 32'h0000_0000)
		rd(OFF_ALL_CLR);
		`CHK(d, 32'h0000_0001)
		rd(OFF_RAW);
		`CHK(d, 32'h0000_0000)
		$display("test errors done");
	endtask : t_errors
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// main sequence
	initial
	begin
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_levels();
		t_mask();
		t_errors();
		finish_test();
	end
	// watchdog
	initial
	begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule : tb
